//--- core/rrc_pkg.sv
// Package of constants and carriers for the register retention control block.
package rrc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  localparam int unsigned NUM_GRP = 16;
  localparam int unsigned G_CORE      = 0;
  localparam int unsigned G_INTR      = 1;
  localparam int unsigned G_PDCR      = 2;
  localparam int unsigned G_BRK       = 3;
  localparam int unsigned G_POUT      = 4;
  localparam int unsigned G_BUS       = 5;
  localparam int unsigned G_DMA       = 6;
  localparam int unsigned G_MTMR      = 7;
  localparam int unsigned G_ADC       = 8;
  localparam int unsigned G_SER_REGS  = 9;
  localparam int unsigned G_SER_SHIFT = 10;
  localparam int unsigned G_WD_CNT    = 11;
  localparam int unsigned G_WD_CS     = 12;
  localparam int unsigned G_WD_RST    = 13;
  localparam int unsigned G_PINFN     = 14;
  localparam int unsigned G_PORT_AB   = 15;

  // Which groups each event initializes, one bit per group index.
  localparam logic [15:0] POR_MASK  = 16'hFFFF;
  localparam logic [15:0] MAN_MASK  = 16'h3FDF;
  localparam logic [15:0] STBY_MASK = 16'h23C0;

  //////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_WDCS   = 8'h08;
  localparam logic [7:0] ADDR_WDRST  = 8'h0C;
  localparam logic [7:0] ADDR_PORTC  = 8'h10;

  localparam int unsigned CTRL_STBY   = 0;
  localparam int unsigned CTRL_SLEEP  = 1;
  localparam int unsigned WDCS_OVERFLOW = 7;
  localparam int unsigned WDCS_MODE   = 6;
  localparam int unsigned WDCS_EN     = 5;
  localparam int unsigned WDCS_CKS_HI = 2;

  localparam logic [7:0] WDCS_RESET  = 8'h18;
  localparam logic [7:0] WDRST_RESET = 8'h1F;
  localparam logic [7:0] PORTC_FILL  = 8'h00;
  localparam logic [2:0] CAUSE_RESET = 3'h0;

  localparam int unsigned SYNC_W = 11;

  //////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_STBY  = 2'b10
  } rrc_state_e;

  typedef struct packed {
    logic [15:0] grp;
    logic        wdcs_part;
  } rrc_init_s;

  typedef struct packed {
    logic       wake;
    logic       man_rst;
    logic       por_rst;
    logic [7:0] port_c;
  } rrc_pins_s;

endpackage : rrc_pkg

//--- core/rrc_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module rrc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Bits accepted only when the last two stages agree, which rejects one-cycle glitches.
  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        dout[i] <= 1'b0;
      end else if (ce && (s2[i] == s3[i])) begin
        dout[i] <= s3[i];
      end
    end
  end
endmodule : rrc_sync

//--- core/rrc_top.sv
// Register retention controller: reset and power-down initialization strobes.
//
// Design decisions made here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module rrc_top (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             por_pin,
  input  wire logic             man_rst_pin,
  input  wire logic             wake_pin,
  input  wire logic [7:0]       port_c_pins,
  input  wire logic             wd_rst_req,
  input  wire logic             wd_rst_manual,
  input  wire logic             wd_overflow,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  output rrc_pkg::rrc_init_s    init,
  output rrc_pkg::rrc_state_e   pd_state,
  output logic      [7:0]       watchdog_ctrl_status,
  output logic      [7:0]       watchdog_reset_ctrl
);
  import rrc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  rrc_pins_s  pin_s;
  rrc_state_e state;
  rrc_state_e next_state;
  rrc_init_s  next_init;
  logic       por_lvl;
  logic       man_lvl;
  logic       por_any;
  logic       man_any;
  logic       stby_go;
  logic       sleep_go;
  logic       wr_en;
  logic       rd_setup;
  logic       addr_ok;
  logic [2:0] cause;
  logic [31:0] next_rdata;

  rrc_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .ce    (ce),
    .din   ({wake_pin, man_rst_pin, por_pin, port_c_pins}),
    .dout  (pin_s)
  );

  assign por_lvl  = pin_s.por_rst;
  assign man_lvl  = pin_s.man_rst;
  // A watchdog reset acts as either reset type, as its own setting selects.
  assign por_any  = por_lvl | (wd_rst_req & ~wd_rst_manual);
  assign man_any  = man_lvl | (wd_rst_req & wd_rst_manual);
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign stby_go  = wr_en & (paddr == ADDR_CTRL) & pwdata[CTRL_STBY] & (state == ST_RUN);
  assign sleep_go = wr_en & (paddr == ADDR_CTRL) & pwdata[CTRL_SLEEP] & (state == ST_RUN)
                    & ~pwdata[CTRL_STBY];

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (stby_go) begin
          next_state = ST_STBY;
        end else if (sleep_go) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP, ST_STBY: begin
        if (pin_s.wake) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
    if (por_any || man_any) begin
      next_state = ST_RUN;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign pd_state = state;

  //////////////////////////////////////////////////////////////////////////////
  // Sleep raises no strobe at all, so every group is held while sleeping.
  genvar g;
  for (g = 0; g < NUM_GRP; g++) begin : g_grp
    if (g == G_WD_RST) begin : g_wdrst
      // Watchdog-caused resets leave this group alone; only the pins and standby entry count.
      assign next_init.grp[g] = (por_lvl & POR_MASK[g]) | (man_lvl & MAN_MASK[g])
                                | (stby_go & STBY_MASK[g]);
    end else begin : g_other
      assign next_init.grp[g] = (por_any & POR_MASK[g]) | (man_any & MAN_MASK[g])
                                | (stby_go & STBY_MASK[g]);
    end
  end
  assign next_init.wdcs_part = stby_go;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init <= '0;
    end else if (ce) begin
      init <= next_init;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overflow sets win over a software clear in the same cycle; a G_WD_CS group init clears them.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      watchdog_ctrl_status <= WDCS_RESET;
    end else if (ce) begin
      if (init.grp[G_WD_CS]) begin
        watchdog_ctrl_status <= WDCS_RESET;
      end else if (init.wdcs_part) begin
        watchdog_ctrl_status[WDCS_OVERFLOW] <= wd_overflow;
        watchdog_ctrl_status[WDCS_MODE]     <= WDCS_RESET[WDCS_MODE];
        watchdog_ctrl_status[WDCS_EN]       <= WDCS_RESET[WDCS_EN];
      end else begin
        if (wr_en && paddr == ADDR_WDCS) begin
          watchdog_ctrl_status[WDCS_MODE]     <= pwdata[WDCS_MODE];
          watchdog_ctrl_status[WDCS_EN]       <= pwdata[WDCS_EN];
          watchdog_ctrl_status[WDCS_CKS_HI:0] <= pwdata[WDCS_CKS_HI:0];
          watchdog_ctrl_status[WDCS_OVERFLOW] <= pwdata[WDCS_OVERFLOW]
                                                 & watchdog_ctrl_status[WDCS_OVERFLOW];
        end
        if (wd_overflow) begin
          watchdog_ctrl_status[WDCS_OVERFLOW] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      watchdog_reset_ctrl <= WDRST_RESET;
    end else if (ce) begin
      if (init.grp[G_WD_RST]) begin
        watchdog_reset_ctrl <= WDRST_RESET;
      end else if (wr_en && paddr == ADDR_WDRST) begin
        watchdog_reset_ctrl <= pwdata[7:0];
      end
    end
  end

  // Reset cause flags: bit0 power-on pin, bit1 manual pin, bit2 watchdog. Write 1 clears.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cause <= CAUSE_RESET;
    end else if (ce) begin
      if (wr_en && paddr == ADDR_STATUS) begin
        cause <= (cause & ~pwdata[4:2]) | {wd_rst_req, man_lvl, por_lvl};
      end else begin
        cause <= cause | {wd_rst_req, man_lvl, por_lvl};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // The slave never waits; read data is captured in the setup cycle.
  assign pready  = 1'b1;
  assign addr_ok = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) | (paddr == ADDR_WDCS)
                   | (paddr == ADDR_WDRST) | (paddr == ADDR_PORTC);
  assign pslverr = psel & penable & ~addr_ok;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr)
      ADDR_STATUS: next_rdata = {27'h000_0000, cause, state};
      ADDR_WDCS:   next_rdata = {24'h00_0000, watchdog_ctrl_status};
      ADDR_WDRST:  next_rdata = {24'h00_0000, watchdog_reset_ctrl};
      // The upper byte carries no meaning and software must not rely on it.
      ADDR_PORTC:  next_rdata = {16'h0000, PORTC_FILL, pin_s.port_c};
      default:     next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (ce && rd_setup) begin
      prdata <= next_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  por_all_a: assert property ((ce && por_lvl) |=> init.grp == POR_MASK)
    else $error("power-on reset did not initialize every group");

  brk_pout_a: assert property ((ce && man_lvl) |=> init.grp[G_BRK] && init.grp[G_POUT])
    else $error("manual reset missed break or pattern groups");

  bus_keep_a: assert property ((ce && man_any && !por_any && !stby_go)
                               |=> !init.grp[G_BUS] && !init.grp[G_PINFN])
    else $error("manual reset touched power-on-only groups");

  stby_grp_a: assert property ((ce && stby_go && !por_any && !man_any)
                               |=> init.grp == STBY_MASK && init.wdcs_part)
    else $error("standby entry strobes wrong groups");

  ser_shift_a: assert property ((ce && stby_go && !por_any && !man_any)
                                |=> !init.grp[G_SER_SHIFT] && init.grp[G_SER_REGS])
    else $error("standby handled serial groups wrongly");

  wd_cnt_a: assert property ((ce && state != ST_RUN && !por_any && !man_any)
                             |=> !init.grp[G_WD_CNT] && !init.grp[G_WD_CS])
    else $error("watchdog counter disturbed in power-down");

  wdcs_part_a: assert property ((ce && init.wdcs_part && !init.grp[G_WD_CS])
                                && !wd_overflow
                                |=> watchdog_ctrl_status[7:5] == 3'b000
                                    && watchdog_ctrl_status[2:0] == $past(watchdog_ctrl_status[2:0]))
    else $error("standby partial clear of watchdog control wrong");

  wd_origin_a: assert property ((ce && wd_rst_req && !por_lvl && !man_lvl && !stby_go)
                                |=> !init.grp[G_WD_RST] ##1 !ce || watchdog_reset_ctrl == $past(watchdog_reset_ctrl))
    else $error("watchdog reset initialized reset control");

  portc_hi_a: assert property ((ce && rd_setup && paddr == ADDR_PORTC)
                               |=> prdata[15:8] == PORTC_FILL)
    else $error("port C upper byte not filler");

  portc_lo_a: assert property ((ce && rd_setup && paddr == ADDR_PORTC)
                               |=> prdata[7:0] == $past(pin_s.port_c))
    else $error("port C low byte not live pins");

  sleep_hold_a: assert property ((ce && state == ST_SLEEP && !por_any && !man_any)
                                 |=> init == '0)
    else $error("sleep initialized a group");

  man_core_a: assert property ((ce && man_any)
                               |=> init.grp[G_CORE] && init.grp[G_INTR] && init.grp[G_PDCR])
    else $error("manual reset missed core, interrupt or power-down group");

  man_port_a: assert property ((ce && man_lvl && !por_any)
                               |=> !init.grp[G_PORT_AB] && !init.grp[G_PINFN])
    else $error("manual reset touched pin function or port groups");

  man_dma_a: assert property ((ce && man_any)
                              |=> init.grp[G_DMA] && init.grp[G_MTMR] && init.grp[G_ADC])
    else $error("manual reset missed transfer, timer or converter group");

  man_ser_a: assert property ((ce && man_any)
                              |=> init.grp[G_SER_REGS] && init.grp[G_SER_SHIFT])
    else $error("manual reset missed a serial group");

  man_wd_a: assert property ((ce && man_any)
                             |=> init.grp[G_WD_CNT] && init.grp[G_WD_CS])
    else $error("manual reset missed a watchdog group");

  wdrst_pin_a: assert property ((ce && (por_lvl || man_lvl))
                                |=> init.grp[G_WD_RST])
    else $error("reset pin left watchdog reset control alone");

  wdcs_init_a: assert property ((ce && init.grp[G_WD_CS])
                                |=> watchdog_ctrl_status == WDCS_RESET)
    else $error("watchdog control not restored to reset value");

  wdrst_init_a: assert property ((ce && init.grp[G_WD_RST])
                                 |=> watchdog_reset_ctrl == WDRST_RESET)
    else $error("watchdog reset control not restored to reset value");

  overflow_set_a: assert property ((ce && wd_overflow && !init.grp[G_WD_CS])
                                   |=> watchdog_ctrl_status[WDCS_OVERFLOW])
    else $error("overflow event lost");

  wdcs_keep_a: assert property ((ce && !init.grp[G_WD_CS] && !init.wdcs_part && !wr_en)
                                && !wd_overflow |=> $stable(watchdog_ctrl_status))
    else $error("watchdog control changed with no cause");

  wdrst_keep_a: assert property ((ce && !init.grp[G_WD_RST] && !wr_en)
                                 |=> $stable(watchdog_reset_ctrl))
    else $error("watchdog reset control changed with no cause");

  ce_freeze_a: assert property (!ce
                                |=> $stable(init) && $stable(state) && $stable(prdata))
    else $error("state moved while clock enable was low");

  state_hold_a: assert property ((ce && state != ST_RUN && !pin_s.wake)
                                 && !por_any && !man_any |=> $stable(state))
    else $error("power-down state left with no wake or reset");

  por_seen_c:   cover property (ce && por_lvl ##1 init.grp == POR_MASK);
  stby_seen_c:  cover property (ce && stby_go ##[1:50] state == ST_RUN);
  sleep_wake_c: cover property (state == ST_SLEEP ##[1:50] state == ST_RUN);
  wd_rst_c:     cover property (ce && wd_rst_req && !por_lvl && !man_lvl);
  ce_hold_c:    cover property (!ce ##1 ce);
endmodule : rrc_top

//--- tb/tb_top.sv
// Self-checking bench for the register retention controller.
`timescale 1ns/1ps
module tb_top;
  import rrc_pkg::*;

  logic              clock;
  logic              rst;
  logic              ce;
  logic              por_pin;
  logic              man_rst_pin;
  logic              wake_pin;
  logic [7:0]        port_c_pins;
  logic              wd_rst_req;
  logic              wd_rst_manual;
  logic              wd_overflow;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  rrc_init_s         init;
  rrc_state_e        pd_state;
  logic [7:0]        wdcs_q;
  logic [7:0]        wdrst_q;
  logic [32:0]       rd_q[$];
  logic [15:0]       grp_q[$];
  logic [15:0]       last_grp;
  logic [32:0]       exp_rd;
  int                fail_count;
  int                compares;

  rrc_top i_dut (
    .clock(clock), .rst(rst), .ce(ce), .por_pin(por_pin), .man_rst_pin(man_rst_pin),
    .wake_pin(wake_pin), .port_c_pins(port_c_pins), .wd_rst_req(wd_rst_req),
    .wd_rst_manual(wd_rst_manual), .wd_overflow(wd_overflow), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .init(init), .pd_state(pd_state),
    .watchdog_ctrl_status(wdcs_q), .watchdog_reset_ctrl(wdrst_q)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic mism(input string msg);
    fail_count++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask : mism

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Requests are held until pready is seen high, for up to 49 cycles of slave latency.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    if (!wr) rd_q.push_back(e);
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      mism("bus timeout");
      end_sim();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask : rd

  task automatic settle;
    int n;
    n = 0;
    while ((grp_q.size() != 0 || init.grp !== 16'h0000) && n < 60) begin
      @(posedge clock);
      n++;
    end
    if (n >= 60) begin
      mism("strobe timeout");
      end_sim();
    end
    repeat (2) @(posedge clock);
  endtask : settle

  // Level pins pass a synchroniser, so the strobe lags the pin by a few edges.
  task automatic pin_rst(input logic p, input logic [15:0] e);
    int n;
    n = 0;
    grp_q.push_back(e);
    @(posedge clock);
    por_pin     <= p;
    man_rst_pin <= ~p;
    while (grp_q.size() != 0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20) begin
      mism("pin reset timeout");
      end_sim();
    end
    por_pin     <= 1'b0;
    man_rst_pin <= 1'b0;
    settle();
  endtask : pin_rst

  task automatic wd_rst(input logic m, input logic [15:0] e);
    grp_q.push_back(e);
    @(posedge clock);
    wd_rst_req    <= 1'b1;
    wd_rst_manual <= m;
    @(posedge clock);
    wd_rst_req    <= 1'b0;
    settle();
  endtask : wd_rst

  task automatic wake;
    int n;
    n = 0;
    @(posedge clock);
    wake_pin <= 1'b1;
    while (pd_state !== ST_RUN && n < 30) begin
      @(posedge clock);
      n++;
    end
    if (n >= 30) begin
      mism("wake timeout");
      end_sim();
    end
    wake_pin <= 1'b0;
    repeat (6) @(posedge clock);
  endtask : wake

  //////////////////////////////////////////////////////////////////////////////
  // Every read completion and every rising init strobe consumes the oldest note.
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      compares++;
      if (rd_q.size() == 0) mism("unexpected read");
      else begin
        exp_rd = rd_q.pop_front();
        if ({pslverr, prdata} !== exp_rd) mism($sformatf("read %h exp %h", prdata, exp_rd));
      end
    end
    if (init.grp !== 16'h0000 && last_grp === 16'h0000 && !rst) begin
      compares++;
      if (grp_q.size() == 0) mism("unexpected init strobe");
      else if (init.grp !== grp_q[0]) mism($sformatf("strobe %h exp %h", init.grp, grp_q[0]));
      if (grp_q.size() != 0) void'(grp_q.pop_front());
    end
    last_grp = init.grp;
  end

  initial begin
    repeat (20000) @(posedge clock);
    mism("global timeout");
    end_sim();
  end

  initial begin
    fail_count = 0;
    compares = 0;
    last_grp = 16'h0000;
    {rst, ce, por_pin, man_rst_pin, wake_pin} = 5'b11000;
    {wd_rst_req, wd_rst_manual, wd_overflow, psel, penable, pwrite} = 6'h00;
    {paddr, pwdata, port_c_pins} = 48'h0;
    void'($urandom(49));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_WDCS, {25'h0, WDCS_RESET});
    rd(ADDR_WDRST, {25'h0, WDRST_RESET});
    wr(ADDR_STATUS, 32'h0000_001C);
    rd(ADDR_STATUS, 33'h0_0000_0000);
    $display("test reset values done");
    wr(ADDR_WDCS, 32'h0000_0067);
    wr(ADDR_WDRST, 32'h0000_0055);
    @(posedge clock) wd_overflow <= 1'b1;
    @(posedge clock) wd_overflow <= 1'b0;
    rd(ADDR_WDCS, 33'h0_0000_00FF);
    grp_q.push_back(16'h23C0);
    wr(ADDR_CTRL, 32'h0000_0001);
    settle();
    rd(ADDR_STATUS, 33'h0_0000_0002);
    rd(ADDR_WDCS, 33'h0_0000_001F);
    rd(ADDR_WDRST, {25'h0, WDRST_RESET});
    wake();
    $display("test standby done");
    wr(ADDR_WDCS, 32'h0000_0067);
    wr(ADDR_WDRST, 32'h0000_0055);
    wr(ADDR_CTRL, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0001);
    settle();
    rd(ADDR_STATUS, 33'h0_0000_0001);
    rd(ADDR_WDCS, 33'h0_0000_007F);
    rd(ADDR_WDRST, 33'h0_0000_0055);
    wake();
    $display("test sleep done");
    wd_rst(1'b1, 16'h1FDF);
    rd(ADDR_WDRST, 33'h0_0000_0055);
    rd(ADDR_WDCS, {25'h0, WDCS_RESET});
    wd_rst(1'b0, 16'hDFFF);
    rd(ADDR_WDRST, 33'h0_0000_0055);
    $display("test watchdog resets done");
    pin_rst(1'b0, 16'h3FDF);
    rd(ADDR_WDRST, {25'h0, WDRST_RESET});
    wr(ADDR_WDCS, 32'h0000_0067);
    pin_rst(1'b1, 16'hFFFF);
    rd(ADDR_WDCS, {25'h0, WDCS_RESET});
    $display("test reset pins done");
    @(posedge clock) ce <= 1'b0;
    wr(ADDR_WDRST, 32'h0000_00AA);
    repeat (3) @(posedge clock);
    ce <= 1'b1;
    rd(ADDR_WDRST, {25'h0, WDRST_RESET});
    wr(ADDR_WDRST, 32'h0000_0055);
    @(posedge clock) rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(ADDR_STATUS, 33'h0_0000_0000);
    rd(ADDR_WDRST, {25'h0, WDRST_RESET});
    $display("test clock enable and mid-run reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      port_c_pins <= 8'($urandom());
      repeat (6) @(posedge clock);
      rd(ADDR_PORTC, {17'h0, PORTC_FILL, port_c_pins});
    end
    $display("test port c done");
    rd(8'h20, {1'b1, 32'h0000_0000});
    $display("test unmapped done");
    repeat (4) @(posedge clock);
    end_sim();
  end

endmodule : tb_top
